/* rtl/pswseq_top.v */
/*
 * Power switch and wake sequencer: times switch holds, moves the system
 * between working, S3, S4 and S5, gates wake sources per state and drives
 * the supply, device-power and boot controls.
 * Assumes all inputs synchronous to CLK_I and a free-running standby clock.
 */
`timescale 1ns/1ps
`include "pswseq_defines.vh"
module pswseq_top (
    // Clock, reset, enable
    input  wire       CLK_I,
    input  wire       RST_N_I,
    input  wire       CE_I,
    // Switches
    input  wire       PWR_SW_I,
    input  wire       CHASSIS_CLOSED_I,
    input  wire       INTRUSION_CLR_I,
    // Software configuration
    input  wire       SW_SLEEP_EN_I,
    input  wire [1:0] SLEEP_KIND_I,
    input  wire       SLEEP_REQ_I,
    input  wire       OFF_REQ_I,
    // Wake sources
    input  wire       WAKE_RTC_I,
    input  wire       WAKE_LAN_I,
    input  wire       WAKE_PCIE_I,
    input  wire       WAKE_PS2_I,
    input  wire       WAKE_USB_I,
    input  wire       WAKE_SERIAL_I,
    // Supply and device controls
    output reg        MAIN_PWR_EN_O,
    output reg        DEV_D3_O,
    output reg        MEM_SELF_REFRESH_O,
    output reg        USB_PWR_EN_O,
    output reg        COLD_BOOT_O,
    output reg        RESUME_DISK_O,
    output reg  [3:0] STATE_O,
    output reg        INTRUSION_O
);
    localparam [3:0] ST_S5 = `PSWSEQ_ST_S5;
    localparam [3:0] ST_S0 = `PSWSEQ_ST_S0;
    localparam [3:0] ST_S3 = `PSWSEQ_ST_S3;
    localparam [3:0] ST_S4 = `PSWSEQ_ST_S4;

    reg  [`PSWSEQ_DIV_W-1:0]  div_r;
    reg                       tick_r;
    wire                      sw_clean;
    reg                       sw_prev_r;
    reg  [`PSWSEQ_HOLD_W-1:0] hold_r;
    reg                       long_done_r;
    reg  [3:0]                state_r;
    reg  [3:0]                state_nxt;
    reg                       cold_nxt;
    reg                       disk_nxt;
    wire                      released;
    wire                      short_rel;
    wire                      long_hit;
    wire                      wake_any;
    wire                      wake_s3;

    // Slow tick keeps the hold counter narrow
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_r  <= {`PSWSEQ_DIV_W{1'b0}};
            tick_r <= 1'b0;
        end else if (CE_I) begin
            if (div_r == `PSWSEQ_TICK_DIV - 1) begin
                div_r  <= {`PSWSEQ_DIV_W{1'b0}};
                tick_r <= 1'b1;
            end else begin
                div_r  <= div_r + 1'b1;
                tick_r <= 1'b0;
            end
        end
    end

    pswseq_debounce u_deb (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .tick_i  (tick_r),
        .raw_i   (PWR_SW_I),
        .clean_o (sw_clean)
    );

    assign released  = sw_prev_r & ~sw_clean;
    // Short: released before four seconds of hold
    assign short_rel = released & ~long_done_r &
                       (hold_r < `PSWSEQ_SHORT_TICKS);
    assign long_hit  = sw_clean & ~long_done_r & tick_r &
                       (hold_r == `PSWSEQ_LONG_TICKS - 1);

    // Hold counter saturates once the long action fired
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sw_prev_r   <= 1'b0;
            hold_r      <= {`PSWSEQ_HOLD_W{1'b0}};
            long_done_r <= 1'b0;
        end else if (CE_I) begin
            sw_prev_r <= sw_clean;
            if (!sw_clean) begin
                hold_r      <= {`PSWSEQ_HOLD_W{1'b0}};
                long_done_r <= 1'b0;
            end else if (long_hit) begin
                long_done_r <= 1'b1;
            end else if (tick_r && !long_done_r) begin
                hold_r <= hold_r + 1'b1;
            end
        end
    end

    assign wake_any = WAKE_RTC_I | WAKE_LAN_I | WAKE_PCIE_I |
                      WAKE_PS2_I | short_rel;
    assign wake_s3  = wake_any | WAKE_USB_I | WAKE_SERIAL_I;

    always @* begin
        state_nxt = state_r;
        cold_nxt  = 1'b0;
        disk_nxt  = 1'b0;
        case (state_r)
            ST_S5: begin
                if (wake_any) begin
                    state_nxt = ST_S0;
                    cold_nxt  = 1'b1;
                end
            end
            ST_S0: begin
                if (long_hit || OFF_REQ_I) begin
                    state_nxt = ST_S5;
                end else if ((short_rel && SW_SLEEP_EN_I) ||
                             SLEEP_REQ_I) begin
                    // Releases between four and six seconds fall through
                    case (SLEEP_KIND_I)
                        `PSWSEQ_SLP_S4: state_nxt = ST_S4;
                        `PSWSEQ_SLP_S5: state_nxt = ST_S5;
                        default:        state_nxt = ST_S3;
                    endcase
                end
            end
            ST_S3: begin
                if (long_hit) begin
                    state_nxt = ST_S5;
                end else if (wake_s3) begin
                    state_nxt = ST_S0;
                end
            end
            ST_S4: begin
                if (long_hit) begin
                    state_nxt = ST_S5;
                end else if (wake_any) begin
                    state_nxt = ST_S0;
                    disk_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_S5;
            end
        endcase
    end

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r            <= ST_S5;
            STATE_O            <= ST_S5;
            MAIN_PWR_EN_O      <= 1'b0;
            DEV_D3_O           <= 1'b1;
            MEM_SELF_REFRESH_O <= 1'b0;
            USB_PWR_EN_O       <= 1'b0;
            COLD_BOOT_O        <= 1'b0;
            RESUME_DISK_O      <= 1'b0;
        end else if (CE_I) begin
            state_r            <= state_nxt;
            STATE_O            <= state_nxt;
            MAIN_PWR_EN_O      <= (state_nxt == ST_S0);
            DEV_D3_O           <= (state_nxt != ST_S0);
            MEM_SELF_REFRESH_O <= (state_nxt == ST_S3);
            // USB stays powered in S3 only so it can wake the system
            USB_PWR_EN_O       <= (state_nxt == ST_S0) ||
                                  (state_nxt == ST_S3);
            COLD_BOOT_O        <= cold_nxt;
            RESUME_DISK_O      <= disk_nxt;
        end
    end

    // Sticky flag; a closed contact wins over a clear
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INTRUSION_O <= 1'b0;
        end else if (CE_I) begin
            if (CHASSIS_CLOSED_I) begin
                INTRUSION_O <= 1'b1;
            end else if (INTRUSION_CLR_I) begin
                INTRUSION_O <= 1'b0;
            end
        end
    end
endmodule

/* rtl/pswseq_defines.vh */
/*
 * Constants for the power switch and wake sequencer.
 * Assumes a single 50 MHz standby clock; included by bare name.
 */
`ifndef PSWSEQ_DEFINES_VH
`define PSWSEQ_DEFINES_VH

`define PSWSEQ_CLK_HZ        50000000
`define PSWSEQ_TICK_HZ       1000
`define PSWSEQ_TICK_DIV      (`PSWSEQ_CLK_HZ / `PSWSEQ_TICK_HZ)
`define PSWSEQ_SHORT_S       4
`define PSWSEQ_LONG_S        6
`define PSWSEQ_SHORT_TICKS   (`PSWSEQ_SHORT_S * `PSWSEQ_TICK_HZ)
`define PSWSEQ_LONG_TICKS    (`PSWSEQ_LONG_S * `PSWSEQ_TICK_HZ)
`define PSWSEQ_DEB_TICKS     20
`define PSWSEQ_HOLD_W        13
`define PSWSEQ_DIV_W         16
`define PSWSEQ_DEB_W         5

// Sleep kind selects
`define PSWSEQ_SLP_S3        2'h0
`define PSWSEQ_SLP_S4        2'h1
`define PSWSEQ_SLP_S5        2'h2

// One-hot system states
`define PSWSEQ_ST_S5         4'h1
`define PSWSEQ_ST_S0         4'h2
`define PSWSEQ_ST_S3         4'h4
`define PSWSEQ_ST_S4         4'h8

`endif

/* rtl/pswseq_debounce.v */
/*
 * Debouncer for the power switch on the slow tick.
 * Assumes the input is synchronous to CLK and the tick is one cycle long.
 */
`timescale 1ns/1ps
`include "pswseq_defines.vh"
module pswseq_debounce (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire ce_i,
    input  wire tick_i,
    input  wire raw_i,
    output reg  clean_o
);
    reg [`PSWSEQ_DEB_W-1:0] cnt_r;

    // Output follows only after the raw level held for the full count
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r   <= {`PSWSEQ_DEB_W{1'b0}};
            clean_o <= 1'b0;
        end else if (ce_i) begin
            if (raw_i == clean_o) begin
                cnt_r <= {`PSWSEQ_DEB_W{1'b0}};
            end else if (tick_i) begin
                if (cnt_r == `PSWSEQ_DEB_TICKS - 1) begin
                    cnt_r   <= {`PSWSEQ_DEB_W{1'b0}};
                    clean_o <= raw_i;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

/* verification/pswseq_top_asserts.sv */
/* Port checker for pswseq_top, bound below.
   Assumes the power switch stays released during the run. */
`timescale 1ns/1ps
module pswseq_chk (
    // Inputs seen
    input wire       CLK_I, RST_N_I, CE_I, PWR_SW_I, CHASSIS_CLOSED_I,
    input wire       SLEEP_REQ_I, OFF_REQ_I, WAKE_RTC_I, WAKE_LAN_I,
    input wire       WAKE_PCIE_I, WAKE_PS2_I, WAKE_USB_I, WAKE_SERIAL_I,
    // Outputs seen
    input wire       MAIN_PWR_EN_O, DEV_D3_O, MEM_SELF_REFRESH_O,
    input wire       USB_PWR_EN_O, COLD_BOOT_O, RESUME_DISK_O,
    input wire [3:0] STATE_O,
    input wire       INTRUSION_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    wire main_w = WAKE_RTC_I | WAKE_LAN_I | WAKE_PCIE_I | WAKE_PS2_I;
    wire aux_w  = WAKE_USB_I | WAKE_SERIAL_I;
    wire on_w   = STATE_O == 4'h2;
    sequence s_boot; COLD_BOOT_O ##1 !COLD_BOOT_O; endsequence
    sequence s_disk; RESUME_DISK_O ##1 !RESUME_DISK_O; endsequence
    property p_main; CE_I && !on_w && main_w |=> on_w; endproperty
    a_main: assert property (p_main) else $error("wake missed");
    property p_cold; CE_I && STATE_O == 4'h1 && main_w |=> s_boot;
    endproperty
    a_cold: assert property (p_cold) else $error("no cold boot");
    property p_disk; CE_I && STATE_O == 4'h8 && main_w |=> s_disk;
    endproperty
    a_disk: assert property (p_disk) else $error("no resume");
    property p_aux3; CE_I && STATE_O == 4'h4 && aux_w |=> on_w; endproperty
    a_aux3: assert property (p_aux3) else $error("S3 wake missed");
    property p_deep; CE_I && (STATE_O[3] || STATE_O[0]) && !main_w
        && !PWR_SW_I |=> $stable(STATE_O); endproperty
    a_deep: assert property (p_deep) else $error("deep wake taken");
    property p_d3; DEV_D3_O == !on_w && MAIN_PWR_EN_O == on_w; endproperty
    a_d3: assert property (p_d3) else $error("device power wrong");
    property p_mem; MEM_SELF_REFRESH_O == STATE_O[2]
        && USB_PWR_EN_O == (on_w || STATE_O[2]); endproperty
    a_mem: assert property (p_mem) else $error("memory power wrong");
    property p_intr; CE_I && CHASSIS_CLOSED_I |=> INTRUSION_O; endproperty
    a_intr: assert property (p_intr) else $error("intrusion lost");
    property p_s0; CE_I && on_w && !SLEEP_REQ_I && !OFF_REQ_I && !PWR_SW_I
        |=> on_w; endproperty
    a_s0: assert property (p_s0) else $error("left working");
endmodule
bind pswseq_top pswseq_chk u_pswseq_chk (.*);

/* verification/pswseq_wake_src.sv */
/* Model of the front panel switch and the wake sources.
   Assumes the bench calls pulse from its own process. */
`timescale 1ns/1ps
module pswseq_wake_src (
    input  wire       clk_i,
    output reg        pwr_sw_o,
    output reg  [5:0] wake_o
);
    // Switch left released: its debounce alone outlasts the whole run
    initial begin
        pwr_sw_o = 1'b0;
        wake_o = 6'h00;
    end
    // One-cycle event: 0 RTC, 1 LAN, 2 PCIe, 3 PS/2, 4 USB, 5 serial
    task automatic pulse(input int idx);
        @(negedge clk_i);
        wake_o[idx] = 1'b1;
        @(negedge clk_i);
        wake_o[idx] = 1'b0;
    endtask
endmodule

/* verification/pswseq_top_tb.sv */
/* Random and corner-case bench for pswseq_top.
   Assumes the partner model drives the switch and wake sources. */
`timescale 1ns/1ps
`include "pswseq_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
 fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module pswseq_top_tb;
    reg        clk, rst_n, ce, closed, clr, sw_en, slp_req, off_req;
    reg  [1:0] kind;
    reg [31:0] lfsr = 32'hf3a6bcdd;
    wire       sw, main_en, d3, msr, usb_en, cold, resume, intr;
    wire [5:0] wk;
    wire [3:0] st;
    int        fails = 0, check_count = 0;

    pswseq_top u_pswseq_top (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .PWR_SW_I(sw), .CHASSIS_CLOSED_I(closed), .INTRUSION_CLR_I(clr),
        .SW_SLEEP_EN_I(sw_en), .SLEEP_KIND_I(kind), .SLEEP_REQ_I(slp_req),
        .OFF_REQ_I(off_req), .WAKE_RTC_I(wk[0]), .WAKE_LAN_I(wk[1]),
        .WAKE_PCIE_I(wk[2]), .WAKE_PS2_I(wk[3]), .WAKE_USB_I(wk[4]),
        .WAKE_SERIAL_I(wk[5]), .MAIN_PWR_EN_O(main_en), .DEV_D3_O(d3),
        .MEM_SELF_REFRESH_O(msr), .USB_PWR_EN_O(usb_en),
        .COLD_BOOT_O(cold), .RESUME_DISK_O(resume), .STATE_O(st),
        .INTRUSION_O(intr));
    pswseq_wake_src u_pswseq_wake_src (.clk_i(clk), .pwr_sw_o(sw),
        .wake_o(wk));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end

    function automatic [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Sleep kind 3 falls back to S3
    function automatic [3:0] slp_st(input [1:0] k);
        slp_st = k == 2'h1 ? `PSWSEQ_ST_S4 :
                 k == 2'h2 ? `PSWSEQ_ST_S5 : `PSWSEQ_ST_S3;
    endfunction
    task automatic chk_ctl(input [3:0] s);
        `CHK("state", s, st)
        `CHK("main_pwr", s == `PSWSEQ_ST_S0, main_en)
        `CHK("dev_d3", s != `PSWSEQ_ST_S0, d3)
        `CHK("self_refresh", s == `PSWSEQ_ST_S3, msr)
        `CHK("usb_pwr", s[1] | s[2], usb_en)
    endtask
    task automatic req(input bit off, input [1:0] k);
        @(negedge clk);
        kind = k;
        {off_req, slp_req} = {off, !off};
        @(negedge clk);
        {off_req, slp_req} = 2'b00;
    endtask
    task conclude;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {rst_n, closed, clr, slp_req, off_req, kind} = 0;
        ce = 1'b1;
        sw_en = 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk_ctl(`PSWSEQ_ST_S5);
        u_pswseq_wake_src.pulse(1);
        `CHK("cold_boot", 1'b1, cold)
        // First twelve rounds sweep every source against S3 and S5
        for (int n = 0; n < 60; n++) begin : wake_loop
            int i;
            reg [1:0] k;
            lfsr = nxt(lfsr);
            sw_en = lfsr[9];
            i = n < 12 ? n % 6 : lfsr[7:0] % 6;
            k = n < 6 ? 2'h3 : n < 12 ? 2'h2 : lfsr[11:10];
            req(1'b0, k);
            chk_ctl(slp_st(k));
            u_pswseq_wake_src.pulse(i);
            if (i < 4 || slp_st(k) == `PSWSEQ_ST_S3) begin
                `CHK("cold_boot", k == 2'h2, cold)
                `CHK("resume", k == 2'h1, resume)
            end else begin
                chk_ctl(slp_st(k));
                u_pswseq_wake_src.pulse(1);
            end
            chk_ctl(`PSWSEQ_ST_S0);
        end
        $display("wake test done");
        req(1'b1, 2'h0);
        chk_ctl(`PSWSEQ_ST_S5);
        req(1'b0, 2'h0);
        chk_ctl(`PSWSEQ_ST_S5);
        ce = 1'b0;
        u_pswseq_wake_src.pulse(1);
        chk_ctl(`PSWSEQ_ST_S5);
        ce = 1'b1;
        u_pswseq_wake_src.pulse(2);
        chk_ctl(`PSWSEQ_ST_S0);
        $display("request test done");
        @(negedge clk) closed = 1'b1;
        @(negedge clk) clr = 1'b1;
        `CHK("intrusion", 1'b1, intr)
        @(negedge clk) closed = 1'b0;
        `CHK("intrusion", 1'b1, intr)
        @(negedge clk) clr = 1'b0;
        `CHK("intrusion", 1'b0, intr)
        $display("intrusion test done");
        conclude();
    end
endmodule
